// [pkg/scr_pkg.sv]
// Purpose: constants and carrier types of the sequencer control registers
// Assumes: 8-bit register space, one clock
// Notes:   addresses are register offsets on the plain register port
package scr_pkg;
  // register offsets
  localparam logic [7:0] A_BLKCTL   = 8'h1F;
  localparam logic [7:0] A_BANK_TOP = 8'h1E;
  localparam logic [7:0] A_SEQUENCER_CONTROL   = 8'h60;
  localparam logic [7:0] A_RAM      = 8'h61;
  localparam logic [7:0] A_PCLO     = 8'h62;
  localparam logic [7:0] A_PCHI     = 8'h63;
  localparam logic [7:0] A_ACC      = 8'h64;
  localparam logic [7:0] A_SRC      = 8'h65;
  localparam logic [7:0] A_DST      = 8'h66;
  localparam logic [7:0] A_BRKLO    = 8'h67;
  localparam logic [7:0] A_BRKHI    = 8'h68;
  localparam logic [7:0] A_ONES     = 8'h69;
  localparam logic [7:0] A_ZEROS    = 8'h6A;
  localparam logic [7:0] A_FLAGS    = 8'h6B;
  localparam logic [7:0] A_SIND     = 8'h6C;
  localparam logic [7:0] A_DIND     = 8'h6D;
  localparam logic [7:0] A_DEC      = 8'h6E;
  // sequencer control fields
  localparam int B_PERRDIS = 7;
  localparam int B_HALTDIS = 6;
  localparam int B_ILLEGAL_OP_DETECT_DISABLE = 5;
  localparam int B_FAST    = 4;
  localparam int B_BRKIEN  = 3;
  localparam int B_STEP    = 2;
  localparam int B_PCCLR   = 1;
  localparam int B_LOAD    = 0;
  // channel block control, break high, flags, decoder fields
  localparam int B_SELB    = 3;
  localparam int B_WIDE    = 1;
  localparam int B_BREAK_COMPARE_DISABLE  = 7;
  localparam int B_PC8     = 0;
  localparam int B_ZERO    = 1;
  localparam int B_CARRY   = 0;
  localparam int DEC_LSB   = 4;
  localparam int DEC_W     = 3;
  // reset values, strap loads and read constants
  localparam logic [7:0] SEQUENCER_CONTROL_RST = 8'h80;
  localparam logic [7:0] BRKHI_RST  = 8'h80;
  localparam logic [7:0] BLK_DUAL   = 8'h08;
  localparam logic [7:0] BLK_AONLY  = 8'h00;
  localparam logic [7:0] BLK_WIDE   = 8'h02;
  localparam logic [7:0] CONST_ONES = 8'hFF;
  localparam logic [7:0] CONST_ZERO = 8'h00;
  // divider terminal counts: divide by 4 and by 5; last byte index
  localparam logic [2:0] DIV_FAST   = 3'h3;
  localparam logic [2:0] DIV_SLOW   = 3'h4;
  localparam logic [1:0] BYTE_LAST  = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } scr_bus_req_s;
endpackage

// [verilog/scr_top.sv]
// Purpose: sequencer control and working registers, channel block control
// Assumes: inputs synchronous to ref_clk; sequencer core sits outside
// Notes:   host port wins over sequencer port when both write
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - channel-B select steers offsets 00h-1Eh to bank B, else bank A
// - wide configuration forces channel-B select to zero
// - wide: one 16-bit channel, B data high, A control lines used
// - block control loads 08, 00 or 02 from straps on the first clock after reset release
// - parity-check disable resets set and suppresses RAM parity errors
// - host-halt disable blocks host pause only; SCSI interrupt and error events clear it
// - illegal opcode or address raises status and pauses unless disabled
// - sequencer tick is input clock divided by 4 or by 5
// - breakpoint sets status always; pin only with its enable
// - step: each pause release runs one instruction then pauses
// - pointer-clear zeroes program address and clears itself
// - ram access enable lets program port bytes reach sequencer RAM
// - bytes least significant first; address steps after fourth byte
// - writing either program address half zeroes the byte index
// - program address holds the next address to execute
// - break-compare disable resets set; bit 0 is break address bit 8
// - ones port reads FFh, zeros port reads 00h
// - writes to the null destination change nothing
// - flag register: zero in bit 1, carry in bit 0
// - sequencer read of source-indirect fetches then bumps source pointer
// - sequencer write to destination-indirect stores then bumps pointer
// - decoder keeps bits 6-4; reads return one-hot of that value
module scr_top #(
  parameter int PROG_WORDS = 512
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire scr_pkg::scr_bus_req_s host_req,
  output logic [7:0]                host_rdata,
  input  wire scr_pkg::scr_bus_req_s seq_req,
  output logic [7:0]                seq_rdata,
  output logic [7:0]                ind_addr,
  output logic [7:0]                ind_wdata,
  output logic                      ind_wr,
  output logic                      ind_rd,
  input  wire logic [7:0]           ind_rdata,
  input  wire logic                 strap_b_busy_line_n,
  input  wire logic                 strap_b_cd_line_n,
  input  wire logic                 strap_b_message_line_n,
  input  wire logic [7:0]           chan_a_data,
  input  wire logic [7:0]           chan_b_data,
  output logic [15:0]               chan_data_word,
  output logic                      bank_b_select,
  output logic                      wide_mode,
  output logic                      phase_ctl_from_b,
  input  wire logic                 host_pause,
  input  wire logic                 scsi_irq_evt,
  input  wire logic                 illegal_op,
  input  wire logic                 illegal_addr,
  input  wire logic                 alu_zero,
  input  wire logic                 alu_carry,
  input  wire logic                 jump_valid,
  input  wire logic [8:0]           jump_target,
  input  wire logic                 status_clear,
  output logic                      seq_tick,
  output logic                      seq_paused,
  output logic [31:0]               instr_word,
  output logic [8:0]                prog_addr,
  output logic                      break_or_illegal_status,
  output logic                      ram_parity_status,
  output logic                      breakpoint_irq
);

  logic [32:0]          prog_ram [PROG_WORDS];
  logic [7:0]           channel_block_control;
  logic                 strap_done;
  logic [7:0]           sequencer_control;
  logic [8:0]           program_address;
  logic [1:0]           byte_idx;
  logic [23:0]          low_bytes;
  logic [7:0]           alu_result_holding;
  logic [7:0]           source_pointer;
  logic [7:0]           destination_pointer;
  logic [7:0]           break_address_low;
  logic [7:0]           break_address_high;
  logic [2:0]           decoder_input_value;
  logic [2:0]           div_cnt;
  logic                 halted;
  logic                 host_pause_q;
  scr_pkg::scr_bus_req_s wreq;
  logic                 w_en;
  logic                 w_seq;
  logic [32:0]          ram_word;
  logic [31:0]          ram_shift;
  logic                 exec;
  logic [8:0]           next_pc;
  logic                 par_err;
  logic                 ill_evt;
  logic                 brk_hit;
  logic                 ram_wr_byte;
  logic                 ram_rd_byte;
  logic [7:0]           strap_value;

  function automatic logic hit(input logic [7:0] a);
    return w_en && (wreq.addr == a);
  endfunction
  function automatic logic [7:0] rd_val(input logic [7:0] a,
                                        input logic       from_seq);
    logic [7:0] v;
    v = scr_pkg::CONST_ZERO;
    if (a == scr_pkg::A_BLKCTL) begin
      v = channel_block_control;
    end else if (a == scr_pkg::A_SEQUENCER_CONTROL) begin
      v = sequencer_control;
    end else if (a == scr_pkg::A_RAM) begin
      if (sequencer_control[scr_pkg::B_LOAD]) begin
        v = ram_shift[7:0];
      end
    end else if (a == scr_pkg::A_PCLO) begin
      v = program_address[7:0];
    end else if (a == scr_pkg::A_PCHI) begin
      v = {7'h00, program_address[8]};
    end else if (a == scr_pkg::A_ACC) begin
      v = alu_result_holding;
    end else if (a == scr_pkg::A_SRC) begin
      v = source_pointer;
    end else if (a == scr_pkg::A_DST) begin
      v = destination_pointer;
    end else if (a == scr_pkg::A_BRKLO) begin
      v = break_address_low;
    end else if (a == scr_pkg::A_BRKHI) begin
      v = break_address_high;
    end else if (a == scr_pkg::A_ONES) begin
      v = scr_pkg::CONST_ONES;
    end else if (a == scr_pkg::A_ZEROS) begin
      v = scr_pkg::CONST_ZERO;
    end else if (a == scr_pkg::A_FLAGS) begin
      v[scr_pkg::B_ZERO]  = alu_zero;
      v[scr_pkg::B_CARRY] = alu_carry;
    end else if (a == scr_pkg::A_SIND) begin
      if (from_seq) begin
        v = ind_rdata;
      end
    end else if (a == scr_pkg::A_DEC) begin
      v = 8'(8'h01 << decoder_input_value);
    end
    return v;
  endfunction
  // write source selection
  assign w_en  = host_req.wr | seq_req.wr;
  assign w_seq = ~host_req.wr;
  assign wreq  = host_req.wr ? host_req : seq_req;
  // program RAM access through the byte port
  assign ram_word    = prog_ram[program_address];
  assign ram_shift   = ram_word[31:0] >> {byte_idx, 3'h0};
  assign ram_wr_byte = hit(scr_pkg::A_RAM)
                       & sequencer_control[scr_pkg::B_LOAD];
  assign ram_rd_byte = host_req.rd & (host_req.addr == scr_pkg::A_RAM)
                       & sequencer_control[scr_pkg::B_LOAD];
  // sequencer clock divider
  assign seq_tick = (div_cnt >= (sequencer_control[scr_pkg::B_FAST]
                    ? scr_pkg::DIV_FAST : scr_pkg::DIV_SLOW));
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 3'h0;
    end else if (seq_tick) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end
  // execution and fault events
  assign seq_paused = halted | (host_pause
                      & ~sequencer_control[scr_pkg::B_HALTDIS]);
  assign exec       = seq_tick & ~seq_paused;
  assign next_pc    = jump_valid ? jump_target
                      : program_address + 9'h001;
  assign par_err    = exec & ~sequencer_control[scr_pkg::B_PERRDIS]
                      & (^ram_word);
  assign ill_evt    = exec & ~sequencer_control[scr_pkg::B_ILLEGAL_OP_DETECT_DISABLE]
                      & (illegal_op | illegal_addr);
  assign brk_hit    = exec & ~break_address_high[scr_pkg::B_BREAK_COMPARE_DISABLE]
                      & (next_pc == {break_address_high[scr_pkg::B_PC8],
                                     break_address_low});
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      halted       <= 1'b0;
      host_pause_q <= 1'b0;
    end else begin
      host_pause_q <= host_pause;
      if (par_err | ill_evt | brk_hit) begin
        halted <= 1'b1;
      end else if (exec & sequencer_control[scr_pkg::B_STEP]) begin
        halted <= 1'b1;
      end else if (host_pause_q & ~host_pause) begin
        halted <= 1'b0;
      end
    end
  end
  // sticky status, set beats clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      break_or_illegal_status <= 1'b0;
      ram_parity_status       <= 1'b0;
    end else begin
      if (brk_hit | ill_evt) begin
        break_or_illegal_status <= 1'b1;
      end else if (status_clear) begin
        break_or_illegal_status <= 1'b0;
      end
      if (par_err) begin
        ram_parity_status <= 1'b1;
      end else if (status_clear) begin
        ram_parity_status <= 1'b0;
      end
    end
  end
  assign breakpoint_irq = break_or_illegal_status
                          & sequencer_control[scr_pkg::B_BRKIEN];
  // sequencer control register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sequencer_control <= scr_pkg::SEQUENCER_CONTROL_RST;
    end else begin
      if (hit(scr_pkg::A_SEQUENCER_CONTROL)) begin
        sequencer_control <= wreq.wdata;
        sequencer_control[scr_pkg::B_PCCLR] <= 1'b0;
        if (!w_seq) begin
          sequencer_control[scr_pkg::B_HALTDIS] <=
            sequencer_control[scr_pkg::B_HALTDIS];
        end
      end
      if (scsi_irq_evt | ill_evt | par_err) begin
        sequencer_control[scr_pkg::B_HALTDIS] <= 1'b0;
      end
    end
  end
  // program address and byte index
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      program_address <= 9'h000;
      byte_idx        <= 2'h0;
    end else if (hit(scr_pkg::A_SEQUENCER_CONTROL)
                 && wreq.wdata[scr_pkg::B_PCCLR]) begin
      program_address <= 9'h000;
      byte_idx        <= 2'h0;
    end else if (hit(scr_pkg::A_PCLO)) begin
      program_address[7:0] <= wreq.wdata;
      byte_idx             <= 2'h0;
    end else if (hit(scr_pkg::A_PCHI)) begin
      program_address[8] <= wreq.wdata[scr_pkg::B_PC8];
      byte_idx           <= 2'h0;
    end else if (ram_wr_byte | ram_rd_byte) begin
      byte_idx <= byte_idx + 2'h1;
      if (byte_idx == scr_pkg::BYTE_LAST) begin
        program_address <= program_address + 9'h001;
      end
    end else if (exec) begin
      program_address <= next_pc;
    end
  end
  // RAM word assembly, low byte first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_bytes <= 24'h000000;
    end else if (ram_wr_byte) begin
      low_bytes <= {wreq.wdata, low_bytes[23:8]};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (ram_wr_byte && byte_idx == scr_pkg::BYTE_LAST) begin
      prog_ram[program_address] <= {^{wreq.wdata, low_bytes},
                                    wreq.wdata, low_bytes};
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      instr_word <= 32'h00000000;
      prog_addr  <= 9'h000;
    end else begin
      instr_word <= ram_word[31:0];
      prog_addr  <= program_address;
    end
  end
  // working registers and index pointers
  assign ind_rd    = seq_req.rd & (seq_req.addr == scr_pkg::A_SIND);
  assign ind_wr    = w_seq & hit(scr_pkg::A_DIND);
  assign ind_wdata = wreq.wdata;
  assign ind_addr  = ind_wr ? destination_pointer : source_pointer;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alu_result_holding  <= 8'h00;
      decoder_input_value <= 3'h0;
    end else begin
      if (hit(scr_pkg::A_ACC)) begin
        alu_result_holding <= wreq.wdata;
      end
      if (hit(scr_pkg::A_DEC)) begin
        decoder_input_value <= wreq.wdata[scr_pkg::DEC_LSB +:
                                          scr_pkg::DEC_W];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      source_pointer      <= 8'h00;
      destination_pointer <= 8'h00;
    end else begin
      if (hit(scr_pkg::A_SRC)) begin
        source_pointer <= wreq.wdata;
      end else if (ind_rd) begin
        source_pointer <= source_pointer + 8'h01;
      end
      if (hit(scr_pkg::A_DST)) begin
        destination_pointer <= wreq.wdata;
      end else if (ind_wr) begin
        destination_pointer <= destination_pointer + 8'h01;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      break_address_low  <= 8'h00;
      break_address_high <= scr_pkg::BRKHI_RST;
    end else begin
      if (hit(scr_pkg::A_BRKLO)) begin
        break_address_low <= wreq.wdata;
      end
      if (hit(scr_pkg::A_BRKHI)) begin
        break_address_high <= wreq.wdata & {1'b1, 6'h00, 1'b1};
      end
    end
  end

  // channel block control with strap capture after reset release
  always_comb begin
    if (!strap_b_busy_line_n) begin
      strap_value = scr_pkg::BLK_DUAL;
    end else if (!strap_b_cd_line_n) begin
      strap_value = scr_pkg::BLK_WIDE;
    end else if (!strap_b_message_line_n) begin
      strap_value = scr_pkg::BLK_AONLY;
    end else begin
      strap_value = scr_pkg::BLK_DUAL;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      channel_block_control <= scr_pkg::BLK_DUAL;
      strap_done            <= 1'b0;
    end else if (!strap_done) begin
      channel_block_control <= strap_value;
      strap_done            <= 1'b1;
    end else if (hit(scr_pkg::A_BLKCTL)) begin
      channel_block_control <= 8'h00;
      channel_block_control[scr_pkg::B_WIDE] <=
        wreq.wdata[scr_pkg::B_WIDE];
      channel_block_control[scr_pkg::B_SELB] <=
        wreq.wdata[scr_pkg::B_SELB]
        & ~wreq.wdata[scr_pkg::B_WIDE];
    end
  end

  assign wide_mode        = channel_block_control[scr_pkg::B_WIDE];
  assign bank_b_select    = channel_block_control[scr_pkg::B_SELB];
  assign phase_ctl_from_b = bank_b_select & ~wide_mode;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chan_data_word <= 16'h0000;
    end else if (wide_mode) begin
      chan_data_word <= {chan_b_data, chan_a_data};
    end else begin
      chan_data_word <= {8'h00, bank_b_select ? chan_b_data
                                              : chan_a_data};
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata <= 8'h00;
      seq_rdata  <= 8'h00;
    end else begin
      host_rdata <= host_req.rd ? rd_val(host_req.addr, 1'b0) : 8'h00;
      seq_rdata  <= seq_req.rd ? rd_val(seq_req.addr, 1'b1) : 8'h00;
    end
  end

endmodule

`default_nettype wire

// [tb/scr_properties.sv]
// Purpose: port-level checks of the sequencer control registers
// Assumes: one clock domain, nrst asynchronous active low
// Notes:   bound to scr_top from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module scr_properties (
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire scr_pkg::scr_bus_req_s host_req,
  input wire logic [7:0]            host_rdata,
  input wire scr_pkg::scr_bus_req_s seq_req,
  input wire logic                  ind_wr,
  input wire logic                  ind_rd,
  input wire logic [7:0]            chan_a_data,
  input wire logic [7:0]            chan_b_data,
  input wire logic [15:0]           chan_data_word,
  input wire logic                  bank_b_select,
  input wire logic                  wide_mode,
  input wire logic                  seq_tick,
  input wire logic                  break_or_illegal_status,
  input wire logic                  breakpoint_irq
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_wide_sel;
    wide_mode |-> !bank_b_select;
  endproperty
  a_wide_sel: assert property (p_wide_sel) else $error("select in wide");

  property p_wide_word;
    wide_mode ##1 wide_mode |->
      chan_data_word == $past({chan_b_data, chan_a_data});
  endproperty
  a_wide_word: assert property (p_wide_word) else $error("wide word");

  property p_const;
    host_req.rd && host_req.addr inside {8'h69, 8'h6A} |=>
      host_rdata == {8{$past(host_req.addr) == 8'h69}};
  endproperty
  a_const: assert property (p_const) else $error("constant port");

  property p_unmapped;
    host_req.rd && host_req.addr == 8'h70 |=> host_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");

  property p_flags;
    host_req.rd && host_req.addr == 8'h6B |=> host_rdata[7:2] == 6'h00;
  endproperty
  a_flags: assert property (p_flags) else $error("flag bits");

  property p_dec;
    host_req.rd && host_req.addr == 8'h6E |=> $onehot(host_rdata);
  endproperty
  a_dec: assert property (p_dec) else $error("decoder");

  property p_tick_min;
    seq_tick |=> !seq_tick [*3];
  endproperty
  a_tick_min: assert property (p_tick_min) else $error("tick fast");

  property p_tick_max;
    seq_tick |-> ##[1:10] seq_tick;
  endproperty
  a_tick_max: assert property (p_tick_max) else $error("tick slow");

  property p_ind_rd;
    ind_rd == (seq_req.rd && seq_req.addr == 8'h6C);
  endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect read");

  property p_ind_wr;
    ind_wr == (!host_req.wr && seq_req.wr && seq_req.addr == 8'h6D);
  endproperty
  a_ind_wr: assert property (p_ind_wr) else $error("indirect write");

  property p_irq;
    breakpoint_irq |-> break_or_illegal_status;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without status");
endmodule
`default_nettype wire

// [tb/test_sequencer_control_registers.sv]
// Purpose: directed bench for the sequencer control registers
// Assumes: host pause held high except where the sequencer must run
// Notes:   reads are checked in the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module test_sequencer_control_registers;
  logic                  ref_clk = 1'b0;
  logic                  nrst = 1'b0;
  scr_pkg::scr_bus_req_s hq = '0;
  scr_pkg::scr_bus_req_s sq = '0;
  logic [7:0]            ind_rdata = 8'hA5;
  logic [7:0]            ca = 8'h3C;
  logic [7:0]            cb = 8'hC3;
  logic                  sb = 1'b1, sc = 1'b1, sm = 1'b1;
  logic                  hp = 1'b1, scsi = 1'b0, iop = 1'b0, ila = 1'b0;
  logic                  pcb;
  logic                  az = 1'b0, ac = 1'b0, sclr = 1'b0;
  logic [7:0]            hr, sr, ia, iw;
  logic                  iwr, ird, bsel, wide, tick, paused, bis, rps, birq;
  logic [15:0]           cw;
  logic [31:0]           iword;
  logic [8:0]            pa;
  int                    n_fail = 0;
  int                    comparisons = 0;

  initial forever #4 ref_clk = ~ref_clk;

  scr_top dut (
    .ref_clk(ref_clk), .nrst(nrst), .host_req(hq), .host_rdata(hr),
    .seq_req(sq), .seq_rdata(sr), .ind_addr(ia), .ind_wdata(iw),
    .ind_wr(iwr), .ind_rd(ird), .ind_rdata(ind_rdata),
    .strap_b_busy_line_n(sb), .strap_b_cd_line_n(sc),
    .strap_b_message_line_n(sm), .chan_a_data(ca), .chan_b_data(cb),
    .chan_data_word(cw), .bank_b_select(bsel), .wide_mode(wide),
    .phase_ctl_from_b(pcb), .host_pause(hp), .scsi_irq_evt(scsi),
    .illegal_op(iop), .illegal_addr(ila), .alu_zero(az), .alu_carry(ac),
    .jump_valid(1'b0), .jump_target(9'h000), .status_clear(sclr),
    .seq_tick(tick), .seq_paused(paused), .instr_word(iword),
    .prog_addr(pa), .break_or_illegal_status(bis),
    .ram_parity_status(rps), .breakpoint_irq(birq)
  );

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input bit s, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    if (s) sq <= '{a, d, 1'b1, 1'b0};
    else hq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    sq <= '0;
    hq <= '0;
  endtask

  task automatic rd(input bit s, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    if (s) sq <= '{a, 8'h00, 1'b0, 1'b1};
    else hq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    sq <= '0;
    hq <= '0;
    #1 chk({8'h00, s ? sr : hr}, {8'h00, e});
  endtask

  task automatic rst(input logic b, input logic c, input logic m);
    @(posedge ref_clk);
    nrst <= 1'b0;
    sb <= b;
    sc <= c;
    sm <= m;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic pulse_irq_and_clear;
    @(posedge ref_clk);
    scsi <= 1'b1;
    sclr <= 1'b1;
    @(posedge ref_clk);
    scsi <= 1'b0;
    sclr <= 1'b0;
  endtask

  task automatic t_straps;
    rst(1'b1, 1'b1, 1'b0);
    rd(0, 8'h1F, 8'h00);
    rst(1'b1, 1'b0, 1'b0);
    rd(0, 8'h1F, 8'h02);
    chk(16'(wide), 16'h0001);
    rst(1'b0, 1'b0, 1'b0);
    rd(0, 8'h1F, 8'h08);
    rst(1'b1, 1'b1, 1'b1);
    rd(0, 8'h1F, 8'h08);
    chk(16'(bsel), 16'h0001);
    rd(0, 8'h60, 8'h80);
    rd(0, 8'h68, 8'h80);
  endtask

  task automatic t_blk;
    wr(0, 8'h1F, 8'h0A);
    rd(0, 8'h1F, 8'h02);
    chk(16'(bsel), 16'h0000);
    chk(cw, {cb, ca});
    chk(16'(pcb), 16'h0000);
    wr(0, 8'h1F, 8'h08);
    rd(0, 8'h1F, 8'h08);
    chk(cw, {8'h00, cb});
    chk(16'(pcb), 16'h0001);
  endtask

  task automatic t_regs;
    int v;
    wr(0, 8'h64, 8'h33);
    wr(0, 8'h6A, 8'h55);
    rd(0, 8'h64, 8'h33);
    rd(0, 8'h6A, 8'h00);
    rd(0, 8'h69, 8'hFF);
    rd(0, 8'h70, 8'h00);
    wr(0, 8'h63, 8'hFF);
    rd(0, 8'h63, 8'h01);
    wr(0, 8'h68, 8'h7F);
    rd(0, 8'h68, 8'h01);
    wr(0, 8'h68, 8'h80);
    @(posedge ref_clk);
    az <= 1'b1;
    rd(0, 8'h6B, 8'h02);
    for (v = 0; v < 8; v++) begin
      wr(1, 8'h6E, {1'b1, v[2:0], 4'hF});
      rd(1, 8'h6E, 8'h01 << v);
    end
    rd(0, 8'h6E, 8'h80);
    wr(0, 8'h60, 8'hC0);
    rd(0, 8'h60, 8'h80);
    wr(1, 8'h60, 8'hC0);
    rd(0, 8'h60, 8'hC0);
    pulse_irq_and_clear;
    rd(0, 8'h60, 8'h80);
  endtask

  task automatic t_ram;
    int i;
    wr(0, 8'h60, 8'h81);
    wr(0, 8'h62, 8'h05);
    wr(0, 8'h63, 8'h00);
    for (i = 0; i < 4; i++) wr(0, 8'h61, 8'(8'h11 * (i + 1)));
    rd(0, 8'h62, 8'h06);
    wr(0, 8'h60, 8'h80);
    wr(0, 8'h60, 8'h81);
    wr(0, 8'h62, 8'h05);
    rd(0, 8'h61, 8'h11);
    rd(0, 8'h61, 8'h22);
    wr(0, 8'h63, 8'h00);
    for (i = 0; i < 4; i++) rd(0, 8'h61, 8'(8'h11 * (i + 1)));
    rd(0, 8'h62, 8'h06);
    wr(0, 8'h60, 8'h80);
    wr(0, 8'h62, 8'h10);
    wr(0, 8'h60, 8'h82);
    rd(0, 8'h62, 8'h00);
    rd(0, 8'h60, 8'h80);
  endtask

  task automatic t_ind;
    wr(1, 8'h65, 8'h40);
    wr(1, 8'h66, 8'h90);
    @(posedge ref_clk);
    sq <= '{8'h6C, 8'h00, 1'b0, 1'b1};
    #1 chk({7'h00, ird, ia}, 16'h0140);
    @(posedge ref_clk);
    sq <= '{8'h6D, 8'h77, 1'b1, 1'b0};
    #1 chk({8'h00, sr}, 16'h00A5);
    chk({ia, iw}, 16'h9077);
    @(posedge ref_clk);
    sq <= '0;
    rd(1, 8'h66, 8'h91);
    rd(0, 8'h6C, 8'h00);
    rd(1, 8'h65, 8'h41);
  endtask

  task automatic t_tick(input logic [7:0] c, input int e);
    int i;
    int n;
    wr(0, 8'h60, c);
    i = 0;
    do begin @(posedge ref_clk); #1; i++; end while (!tick && i < 12);
    chk(16'(i < 12), 16'h0001);
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end while (!tick && n < 12);
    chk(16'(n), 16'(e));
  endtask

  task automatic t_brk;
    int i;
    wr(0, 8'h67, 8'h02);
    wr(0, 8'h68, 8'h00);
    wr(0, 8'h60, 8'h90);
    @(posedge ref_clk);
    hp <= 1'b0;
    for (i = 0; i < 60 && !bis; i++) @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
    chk({14'h0000, bis, paused}, 16'h0003);
    chk(16'(birq), 16'h0000);
    rd(0, 8'h62, 8'h02);
    rd(0, 8'h60, 8'h90);
    wr(0, 8'h60, 8'h98);
    #1 chk(16'(birq), 16'h0001);
    wr(0, 8'h68, 8'h80);
    wr(0, 8'h60, 8'hB0);
    @(posedge ref_clk);
    hp <= 1'b1;
    iop <= 1'b1;
    pulse_irq_and_clear;
    @(posedge ref_clk);
    hp <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk({14'h0000, bis, paused}, 16'h0000);
    iop <= 1'b0;
    ila <= 1'b1;
    wr(0, 8'h60, 8'h90);
    repeat (40) @(posedge ref_clk);
    chk({14'h0000, bis, paused}, 16'h0003);
    ila <= 1'b0;
  endtask

  task automatic t_step;
    int i;
    hp <= 1'b1;
    wr(0, 8'h62, 8'h05);
    wr(0, 8'h60, 8'h14);
    #1 chk(iword[31:16], 16'h4433);
    chk(iword[15:0], 16'h2211);
    chk(16'(pa), 16'h0005);
    hp <= 1'b0;
    for (i = 0; i < 12 && pa != 9'h006; i++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    chk(16'(paused), 16'h0001);
    chk(16'(rps), 16'h0000);
    rd(0, 8'h62, 8'h06);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    t_straps;
    t_blk;
    t_regs;
    t_ram;
    t_ind;
    t_tick(8'h90, 4);
    t_tick(8'h80, 5);
    t_brk;
    t_step;
    give_verdict;
  end
endmodule

bind scr_top scr_properties u_props (
  .ref_clk, .nrst, .host_req, .host_rdata, .seq_req, .ind_wr, .ind_rd,
  .chan_a_data, .chan_b_data, .chan_data_word, .bank_b_select, .wide_mode,
  .seq_tick, .break_or_illegal_status, .breakpoint_irq
);
`default_nettype wire
